// ### hw/irs_ctrl.sv
// Purpose: serial bus controller rate, hold timing and address setup
// Assumes: apb slave on pclk, low-power inputs from pclk logic
// Notes:   lines are open drain: oe high pulls the line low
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module irs_ctrl
  import irs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wait_state,
  input  wire logic        light_sleep_state,
  input  wire logic        deep_sleep_state,
  input  wire logic        port_c_line_zero_i,
  output logic             port_c_line_zero_o,
  output logic             port_c_line_zero_oe,
  input  wire logic        port_c_line_one_i,
  output logic             port_c_line_one_o,
  output logic             port_c_line_one_oe,
  output logic             irq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  own_address_register;
  logic [7:0]  rate_divider_register;
  logic [2:0]  control;
  logic [4:0]  flags;
  logic [4:0]  mask;
  logic [7:0]  rx_data;
  logic [11:0] tbl_div;
  logic [9:0]  tbl_dhold;
  logic [10:0] tbl_shold;
  logic [10:0] tbl_phold;
  logic [1:0]  pins_s;
  logic        scl_d;
  logic        sda_d;
  irs_state_e  state;
  logic [15:0] cnt;
  logic [3:0]  bit_idx;
  logic [7:0]  shreg;
  logic        scl_oe;
  logic        sda_oe;
  logic        master;
  logic        ack;
  logic        ev_done;
  logic        ev_arb;
  logic        busy;
  logic        mon_on;
  logic [3:0]  mon_cnt;
  logic [6:0]  mon_byte;
  logic        hdr_seen;
  logic        ev_addr;
  logic        ev_gcall;
  logic        ev_ext;

  // the wait state deliberately gates nothing here
  wire unused_wait = wait_state;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire setup   = psel && !penable;
  wire wr_en   = psel && penable && pwrite;
  wire hit_own = (paddr == OFS_OWN_ADDR);
  wire hit_div = (paddr == OFS_RATE_DIV);
  wire hit_ctl = (paddr == OFS_CONTROL);
  wire hit_cmd = (paddr == OFS_COMMAND);
  wire hit_st  = (paddr == OFS_STATUS);
  wire hit_msk = (paddr == OFS_MASK);
  wire hit_rx  = (paddr == OFS_RX_DATA);
  wire mapped  = hit_own || hit_div || hit_ctl || hit_cmd || hit_st || hit_msk || hit_rx;
  wire cmd_wr  = wr_en && hit_cmd;

  // read mux; bit 0 of the address register always reads zero
  wire [31:0] rd_mux =
    hit_own ? {24'h0, own_address_register[7:1], 1'b0} :
    hit_div ? {24'h0, rate_divider_register} :
    hit_ctl ? {29'h0, control} :
    hit_st  ? {21'h0, ack, master, busy, 3'h0, flags} :
    hit_msk ? {27'h0, mask} :
    hit_rx  ? {24'h0, rx_data} : 32'h0;

  // zero wait states; bad addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read data captured in the setup cycle, stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // light sleep leaves these alone; deep sleep entry clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_address_register  <= RST_OWN_ADDR;
      rate_divider_register <= RST_RATE_DIV;
      control               <= RST_CONTROL;
      mask                  <= RST_FLAGS;
    end else if (deep_sleep_state) begin
      own_address_register  <= RST_OWN_ADDR;
      rate_divider_register <= RST_RATE_DIV;
      control               <= RST_CONTROL;
      mask                  <= RST_FLAGS;
    end else if (wr_en) begin
      if (hit_own) begin
        own_address_register <= {pwdata[7:1], 1'b0};
      end else if (hit_div) begin
        rate_divider_register <= pwdata[7:0];
      end else if (hit_ctl) begin
        control <= pwdata[2:0];
      end else if (hit_msk) begin
        mask <= pwdata[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  wire [4:0] ev_set = {ev_ext, ev_done, ev_gcall, ev_addr, ev_arb};
  wire [4:0] w1c    = (wr_en && hit_st) ? pwdata[4:0] : 5'h0;

  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= RST_FLAGS;
    end else if (deep_sleep_state) begin
      flags <= RST_FLAGS;
    end else begin
      flags <= (flags & ~w1c) | ev_set;
    end
  end

  // level output, usable as a wake-up while the core waits
  assign irq = |(flags & mask);

  // ----------------------------------------------------------------
  // rate lookup and scaling
  // ----------------------------------------------------------------
  irs_rate_table u_table (
    .pclk       (pclk),
    .presetn    (presetn),
    .sel        (rate_divider_register[DIV_SEL_HI:0]),
    .divider    (tbl_div),
    .data_hold  (tbl_dhold),
    .start_hold (tbl_shold),
    .stop_hold  (tbl_phold)
  );

  // reserved scale code falls back to a factor of one
  wire [1:0] scale = rate_divider_register[DIV_SCALE_HI:DIV_SCALE_LO];
  wire [1:0] shift = (scale == SCALE_X2) ? 2'd1 :
                     (scale == SCALE_X4) ? 2'd2 : 2'd0;

  // every hold is counted in pclk periods times the factor
  wire [15:0] half_t  = ({4'h0, tbl_div} << shift) >> 1;
  wire [15:0] dhold_t = {6'h0, tbl_dhold} << shift;
  wire [15:0] shold_t = {5'h0, tbl_shold} << shift;
  wire [15:0] phold_t = {5'h0, tbl_phold} << shift;
  wire [15:0] cnt_inc = cnt + 16'h1;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  irs_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({port_c_line_one_i, port_c_line_zero_i}),
    .q       (pins_s)
  );

  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];

  // open drain: only a low level is ever driven
  assign port_c_line_zero_o  = 1'b0;
  assign port_c_line_one_o   = 1'b0;
  assign port_c_line_zero_oe = scl_oe;
  assign port_c_line_one_oe  = sda_oe;

  // ----------------------------------------------------------------
  // master engine
  // ----------------------------------------------------------------
  wire active   = control[CTL_ENABLE] && !light_sleep_state;
  wire do_start = cmd_wr && pwdata[CMD_START];
  wire do_stop  = cmd_wr && pwdata[CMD_STOP];
  wire do_send  = cmd_wr && pwdata[CMD_SEND];
  // lost when we leave the line high but someone holds it low
  wire arb_hit  = !sda_oe && !sda_s && (bit_idx != ACK_SLOT) && cnt == 16'h0;

  // one process so pin enables and counters stay in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= E_IDLE;
      cnt     <= 16'h0;
      bit_idx <= 4'h0;
      shreg   <= 8'h00;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      master  <= 1'b0;
      ack     <= 1'b0;
      ev_done <= 1'b0;
      ev_arb  <= 1'b0;
    end else if (!active || deep_sleep_state) begin
      state   <= E_IDLE; // inactive: release both lines
      cnt     <= 16'h0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      master  <= 1'b0;
      ev_done <= 1'b0;
      ev_arb  <= 1'b0;
      if (deep_sleep_state) ack <= 1'b0;
    end else begin
      ev_done <= 1'b0;
      ev_arb  <= 1'b0;
      case (state)
        E_IDLE: begin
          cnt <= 16'h0;
          if (do_start && !busy) begin
            sda_oe <= 1'b1; // data falls while clock is high
            master <= 1'b1;
            state  <= E_START;
          end
        end
        E_START: begin
          cnt <= cnt_inc;
          if (cnt_inc >= shold_t) begin
            scl_oe  <= 1'b1;
            cnt     <= 16'h0;
            ev_done <= 1'b1;
            state   <= E_PARK;
          end
        end
        E_PARK: begin
          cnt <= 16'h0;
          if (do_send) begin
            shreg   <= pwdata[CMD_DATA +: 8];
            bit_idx <= 4'h0;
            state   <= E_LOW;
          end else if (do_stop) begin
            state <= E_SLOW;
          end
        end
        E_LOW: begin
          cnt <= cnt_inc;
          if (cnt == dhold_t) begin
            sda_oe <= (bit_idx == ACK_SLOT) ? 1'b0 : !shreg[7];
          end
          if (cnt_inc >= half_t) begin
            scl_oe <= 1'b0;
            cnt    <= 16'h0;
            state  <= E_HIGH;
          end
        end
        E_HIGH: begin
          // counting waits for the line to rise, so stretching works
          if (scl_s) begin
            cnt <= cnt_inc;
            if (arb_hit) begin
              master <= 1'b0;
              ev_arb <= 1'b1;
              state  <= E_IDLE;
            end else if (cnt_inc >= half_t) begin
              scl_oe <= 1'b1;
              cnt    <= 16'h0;
              if (bit_idx == ACK_SLOT) begin
                ev_done <= 1'b1;
                state   <= E_PARK;
              end else begin
                bit_idx <= bit_idx + 4'h1;
                shreg   <= {shreg[6:0], 1'b0};
                state   <= E_LOW;
              end
            end
            if (cnt == 16'h0 && bit_idx == ACK_SLOT) begin
              ack <= !sda_s;
            end
          end
        end
        E_SLOW: begin
          cnt <= cnt_inc;
          if (cnt == dhold_t) begin
            sda_oe <= 1'b1;
          end
          if (cnt_inc >= half_t) begin
            scl_oe <= 1'b0;
            cnt    <= 16'h0;
            state  <= E_SHIGH;
          end
        end
        E_SHIGH: begin
          if (scl_s) begin
            cnt <= cnt_inc;
            if (cnt_inc >= phold_t) begin
              sda_oe  <= 1'b0;
              master  <= 1'b0;
              ev_done <= 1'b1;
              state   <= E_IDLE;
            end
          end
        end
        default: begin
          state <= E_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus monitor and address recognition
  // ----------------------------------------------------------------
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det  = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise  = scl_s && !scl_d;
  wire [7:0] byte_now = {mon_byte, sda_s};
  wire last_bit  = mon_on && scl_rise && (mon_cnt == LAST_DATA);
  wire is_hdr    = control[CTL_EXT] && (byte_now[7:3] == EXT_HEADER);
  // second byte carries the low seven address bits, top bit zero
  wire ext_match = hdr_seen && !byte_now[7] && (byte_now[6:0] == own_address_register[7:1]);
  wire own_match = !hdr_seen && (byte_now[7:1] == own_address_register[7:1]);
  wire gc_match  = !hdr_seen && control[CTL_GCALL] && (byte_now[7:1] == GCALL_ADDR);

  // monitor runs on every frame; own frames are not matched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      busy     <= 1'b0;
      mon_on   <= 1'b0;
      mon_cnt  <= 4'h0;
      mon_byte <= 7'h00;
      hdr_seen <= 1'b0;
      rx_data  <= 8'h00;
      ev_addr  <= 1'b0;
      ev_gcall <= 1'b0;
      ev_ext   <= 1'b0;
    end else if (!active || deep_sleep_state) begin
      scl_d    <= scl_s;
      sda_d    <= sda_s;
      busy     <= 1'b0;
      mon_on   <= 1'b0;
      hdr_seen <= 1'b0;
      ev_addr  <= 1'b0;
      ev_gcall <= 1'b0;
      ev_ext   <= 1'b0;
      if (deep_sleep_state) begin
        rx_data <= 8'h00;
      end
    end else begin
      scl_d    <= scl_s;
      sda_d    <= sda_s;
      ev_addr  <= 1'b0;
      ev_gcall <= 1'b0;
      ev_ext   <= 1'b0;
      if (start_det) begin
        busy     <= 1'b1;
        mon_on   <= !master;
        mon_cnt  <= 4'h0;
        hdr_seen <= 1'b0;
      end else if (stop_det) begin
        busy   <= 1'b0;
        mon_on <= 1'b0;
      end else if (mon_on && scl_rise) begin
        mon_byte <= byte_now[6:0];
        mon_cnt  <= mon_cnt + 4'h1;
        if (mon_cnt == ACK_SLOT) begin
          mon_cnt <= 4'h0;
          mon_on  <= hdr_seen; // only a 10-bit header wants a second byte
        end
        if (last_bit) begin
          rx_data <= byte_now;
          if (is_hdr && !hdr_seen) begin
            hdr_seen <= 1'b1;
            ev_ext   <= 1'b1;
          end else begin
            hdr_seen <= 1'b0;
            ev_addr  <= own_match || ext_match;
            ev_gcall <= gc_match;
          end
        end
      end
    end
  end
endmodule

// ### inc/irs_pkg.sv
// Purpose: constants shared by the serial bus rate and address block
// Assumes: apb register map, 200 MHz pclk
// Notes:   field positions are bit indices within a 32-bit word
// ----------------------------------------------------------------
// How it works
// - clock and data lines are two-way
// - keeps running and interrupting in wait state
// - light sleep idles controller, registers kept
// - deep sleep returns all registers to reset
// - own slave address sits in bits 7..1
// - scale field: 00=1, 01=2, 10=4, 11 reserved
// - select field picks divider and three holds
// - line clock = bus clock / (scale * divider)
// - data changes scale*data-hold after clock falls
// - start: clock falls scale*start-hold after data
// - stop: data rises scale*stop-hold after clock
// - sixty-four selectable divider settings
// - lost arbitration drops to slave, flags interrupt
// - general call and 10-bit addressing recognised
// ----------------------------------------------------------------
package irs_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
  localparam logic [7:0] OFS_RATE_DIV = 8'h04;
  localparam logic [7:0] OFS_CONTROL  = 8'h08;
  localparam logic [7:0] OFS_COMMAND  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_MASK     = 8'h14;
  localparam logic [7:0] OFS_RX_DATA  = 8'h18;
  // reset values
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_RATE_DIV = 8'h00;
  localparam logic [2:0] RST_CONTROL  = 3'h0;
  localparam logic [4:0] RST_FLAGS    = 5'h00;
  // control bits
  localparam int CTL_ENABLE = 0;
  localparam int CTL_GCALL  = 1;
  localparam int CTL_EXT    = 2;
  // command bits, write only
  localparam int CMD_START  = 0;
  localparam int CMD_STOP   = 1;
  localparam int CMD_SEND   = 2;
  localparam int CMD_DATA   = 8;
  // sticky status bits, write one to clear
  localparam int ST_ARB     = 0;
  localparam int ST_ADDR    = 1;
  localparam int ST_GCALL   = 2;
  localparam int ST_DONE    = 3;
  localparam int ST_EXT     = 4;
  localparam int NUM_FLAGS  = 5;
  // live status bits
  localparam int ST_BUSY    = 8;
  localparam int ST_MASTER  = 9;
  localparam int ST_ACK     = 10;
  // rate divider layout
  localparam int DIV_SCALE_HI = 7;
  localparam int DIV_SCALE_LO = 6;
  localparam int DIV_SEL_HI   = 5;
  localparam logic [1:0] SCALE_X1 = 2'h0;
  localparam logic [1:0] SCALE_X2 = 2'h1;
  localparam logic [1:0] SCALE_X4 = 2'h2;
  // address patterns
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [4:0] EXT_HEADER = 5'h1E;
  localparam logic [3:0] ACK_SLOT   = 4'h8;
  localparam logic [3:0] LAST_DATA  = 4'h7;
  // one-hot engine states
  typedef enum logic [6:0] {
    E_IDLE  = 7'h01,
    E_START = 7'h02,
    E_LOW   = 7'h04,
    E_HIGH  = 7'h08,
    E_PARK  = 7'h10,
    E_SLOW  = 7'h20,
    E_SHIGH = 7'h40
  } irs_state_e;
endpackage

// ### hw/irs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module irs_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // per-bit stages, reset to the released (high) line level
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta[i] <= 1'b1;
        q[i]    <= 1'b1;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule

// ### hw/irs_rate_table.sv
// Purpose: fixed lookup of line divider and hold values
// Assumes: select is stable for a cycle before use
// Notes:   outputs are registered, one cycle behind select
`timescale 1ns/1ps
module irs_rate_table (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [5:0]  sel,
  output logic      [11:0] divider,
  output logic      [9:0]  data_hold,
  output logic      [10:0] start_hold,
  output logic      [10:0] stop_hold
);
  // 64 entries in select order, eight per line
  localparam logic [11:0] DIV [64] = '{
    12'd20, 12'd22, 12'd24, 12'd26, 12'd28, 12'd30, 12'd34, 12'd40,
    12'd28, 12'd32, 12'd36, 12'd40, 12'd44, 12'd48, 12'd56, 12'd68,
    12'd48, 12'd56, 12'd64, 12'd72, 12'd80, 12'd88, 12'd104, 12'd128,
    12'd80, 12'd96, 12'd112, 12'd128, 12'd144, 12'd160, 12'd192, 12'd240,
    12'd160, 12'd192, 12'd224, 12'd256, 12'd288, 12'd320, 12'd384, 12'd480,
    12'd320, 12'd384, 12'd448, 12'd512, 12'd576, 12'd640, 12'd768, 12'd960,
    12'd640, 12'd768, 12'd896, 12'd1024, 12'd1152, 12'd1280, 12'd1536, 12'd1920,
    12'd1280, 12'd1536, 12'd1792, 12'd2048, 12'd2304, 12'd2560, 12'd3072, 12'd3840};
  localparam logic [9:0] DHOLD [64] = '{
    10'd7, 10'd7, 10'd8, 10'd8, 10'd9, 10'd9, 10'd10, 10'd10,
    10'd7, 10'd7, 10'd9, 10'd9, 10'd11, 10'd11, 10'd13, 10'd13,
    10'd9, 10'd9, 10'd13, 10'd13, 10'd17, 10'd17, 10'd21, 10'd21,
    10'd9, 10'd9, 10'd17, 10'd17, 10'd25, 10'd25, 10'd33, 10'd33,
    10'd17, 10'd17, 10'd33, 10'd33, 10'd49, 10'd49, 10'd65, 10'd65,
    10'd33, 10'd33, 10'd65, 10'd65, 10'd97, 10'd97, 10'd129, 10'd129,
    10'd65, 10'd65, 10'd129, 10'd129, 10'd193, 10'd193, 10'd257, 10'd257,
    10'd129, 10'd129, 10'd257, 10'd257, 10'd385, 10'd385, 10'd513, 10'd513};
  localparam logic [10:0] SHOLD [64] = '{
    11'd6, 11'd7, 11'd8, 11'd9, 11'd10, 11'd11, 11'd13, 11'd16,
    11'd10, 11'd12, 11'd14, 11'd16, 11'd18, 11'd20, 11'd24, 11'd30,
    11'd18, 11'd22, 11'd26, 11'd30, 11'd34, 11'd38, 11'd46, 11'd58,
    11'd38, 11'd46, 11'd54, 11'd62, 11'd70, 11'd78, 11'd94, 11'd118,
    11'd78, 11'd94, 11'd110, 11'd126, 11'd142, 11'd158, 11'd190, 11'd238,
    11'd158, 11'd190, 11'd222, 11'd254, 11'd286, 11'd318, 11'd382, 11'd478,
    11'd318, 11'd382, 11'd446, 11'd510, 11'd574, 11'd638, 11'd766, 11'd958,
    11'd638, 11'd766, 11'd894, 11'd1022, 11'd1150, 11'd1278, 11'd1534, 11'd1918};
  localparam logic [10:0] PHOLD [64] = '{
    11'd11, 11'd12, 11'd13, 11'd14, 11'd15, 11'd16, 11'd18, 11'd21,
    11'd15, 11'd17, 11'd19, 11'd21, 11'd23, 11'd25, 11'd29, 11'd35,
    11'd25, 11'd29, 11'd33, 11'd37, 11'd41, 11'd45, 11'd53, 11'd65,
    11'd41, 11'd49, 11'd57, 11'd65, 11'd73, 11'd81, 11'd97, 11'd121,
    11'd81, 11'd97, 11'd113, 11'd129, 11'd145, 11'd161, 11'd193, 11'd241,
    11'd161, 11'd193, 11'd225, 11'd257, 11'd289, 11'd321, 11'd385, 11'd481,
    11'd321, 11'd385, 11'd449, 11'd513, 11'd577, 11'd641, 11'd769, 11'd961,
    11'd641, 11'd769, 11'd897, 11'd1025, 11'd1153, 11'd1281, 11'd1537, 11'd1921};

  // ----------------------------------------------------------------
  // registered lookup, a constant table rather than arithmetic
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider    <= 12'd20;
      data_hold  <= 10'd7;
      start_hold <= 11'd6;
      stop_hold  <= 11'd11;
    end else begin
      divider    <= DIV[sel];
      data_hold  <= DHOLD[sel];
      start_hold <= SHOLD[sel];
      stop_hold  <= PHOLD[sel];
    end
  end
endmodule

// ### dv/irs_ctrl_properties.sv
// Purpose: port-level checks for the rate and address block
// Assumes: bound to every irs_ctrl instance
// Notes:   pin windows use the shortest hold and divider entries
`timescale 1ns/1ps
module irs_ctrl_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       light_sleep_state,
  input wire logic       deep_sleep_state,
  input wire logic       port_c_line_zero_oe,
  input wire logic       port_c_line_one_oe,
  input wire logic       irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus side: zero wait states, unmapped word refused
  a_ready_zero: assert property (psel && penable |-> pready) else $error("pready low in access");
  a_bad_addr: assert property (psel && penable && paddr == 8'h1C |-> pslverr) else $error("no slave error");
  // sleep inputs
  a_light_idle: assert property (light_sleep_state |=> !port_c_line_zero_oe && !port_c_line_one_oe)
    else $error("lines held in light sleep");
  a_deep_clear: assert property (deep_sleep_state |=> !irq) else $error("irq in deep sleep");
  // line timing: smallest entry still gives ten low cycles and seven of data hold
  a_low_half: assert property ($rose(port_c_line_zero_oe) |-> port_c_line_zero_oe [*8])
    else $error("clock low too short");
  a_data_hold: assert property ($rose(port_c_line_zero_oe) |=> $stable(port_c_line_one_oe) [*5])
    else $error("data moved too early");
  a_start_hold: assert property ($rose(port_c_line_one_oe) && !port_c_line_zero_oe |=> !port_c_line_zero_oe [*5])
    else $error("start hold too short");
  a_stop_hold: assert property ($fell(port_c_line_one_oe) && !port_c_line_zero_oe |-> !$past(port_c_line_zero_oe, 8))
    else $error("stop hold too short");
  c_clock: cover property ($rose(port_c_line_zero_oe));
  c_irq: cover property ($rose(irq));
  c_stop: cover property ($fell(port_c_line_one_oe) && !port_c_line_zero_oe);
endmodule
bind irs_ctrl irs_ctrl_chk i_chk (.*);

// ### dv/irs_peer.sv
// Purpose: other party on the two-wire bus
// Assumes: both lines open drain with pull-ups
// Notes:   may hold data low to take the bus from the block
`timescale 1ns/1ps
module irs_peer (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic grab_sda,
  input  wire logic grab_scl,
  output logic      scl,
  output logic      sda
);
  // wired-and of both parties; released lines float up
  assign scl = !(scl_oe || grab_scl);
  assign sda = !(sda_oe || grab_sda);
endmodule

// ### dv/irs_ctrl_tb.sv
// Purpose: directed checks of the block over apb and pins
// Assumes: 200 MHz pclk, peer answers at once
// Notes:   pin windows allow the two-flop input lag
`timescale 1ns/1ps
module irs_ctrl_tb
  import irs_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, grab = 0, gscl = 0, e;
  logic        wst = 0, light = 0, deep = 0, pready, pslverr, irq, scl, sda, scl_o, sda_o, scl_oe, sda_oe;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  int          err_count = 0, total_checks = 0;
  always #2.5 pclk = ~pclk;
  irs_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_state(wst), .light_sleep_state(light), .deep_sleep_state(deep),
    .port_c_line_zero_i(scl), .port_c_line_zero_o(scl_o), .port_c_line_zero_oe(scl_oe),
    .port_c_line_one_i(sda), .port_c_line_one_o(sda_o), .port_c_line_one_oe(sda_oe), .irq(irq));
  irs_peer i_peer (.scl_oe(scl_oe), .sda_oe(sda_oe), .grab_sda(grab), .grab_scl(gscl), .scl(scl), .sda(sda));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task end_sim;
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      err_count++;
      end_sim();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask
  // counts edges until a line enable reaches v; s picks data (1) or clock (0)
  task wt(input bit s, input logic v, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while ((s ? sda_oe : scl_oe) !== v && c < 9000);
    if (c >= 9000) begin
      err_count++;
      end_sim();
    end
  endtask
  // window check: value c must lie in lo..hi
  task win(input int c, input int lo, input int hi);
    chk((c >= lo && c <= hi) ? 1 : c, 1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rd(OFS_OWN_ADDR, 0);
    apb(1, OFS_OWN_ADDR, 32'h55);
    rd(OFS_OWN_ADDR, 32'h54);
    apb(1, OFS_RATE_DIV, 32'hFF);
    rd(OFS_RATE_DIV, 32'hFF);
    rd(8'h1C, 0);
    chk(e, 1);
  endtask
  // every scale code, with the processor waiting; start and stop holds scale with it
  task t_start;
    int c, f;
    wst <= 1;
    apb(1, OFS_CONTROL, 1);
    for (int s = 0; s < 4; s++) begin
      f = (s == 1) ? 2 : (s == 2) ? 4 : 1;
      apb(1, OFS_STATUS, 32'h08);
      apb(1, OFS_MASK, (s > 0) ? 32'h08 : 32'h00);
      apb(1, OFS_RATE_DIV, s << 6);
      apb(1, OFS_COMMAND, 1);
      wt(1, 1, c);
      wt(0, 1, c);
      win(c, 6 * f - 1, 6 * f + 1);
      @(posedge pclk);
      #1;
      chk(irq, s > 0);
      apb(1, OFS_STATUS, 32'h08);
      #1;
      chk(irq, 0);
      apb(1, OFS_COMMAND, 2);
      wt(0, 0, c);
      wt(1, 0, c);
      win(c, 11 * f + 1, 11 * f + 4);
    end
    wst <= 0;
  endtask
  // byte 0xA5 at the fastest entry, then the peer takes the bus on bit 5
  task t_send;
    int c;
    apb(1, OFS_RATE_DIV, 0);
    apb(1, OFS_MASK, 32'h01);
    apb(1, OFS_COMMAND, 1);
    wt(0, 1, c);
    apb(1, OFS_STATUS, 32'h08);
    apb(1, OFS_COMMAND, 32'hA504);
    wt(0, 0, c);
    wt(0, 1, c);
    win(c, 11, 14);
    wt(1, 1, c);
    win(c, 6, 9);
    wt(1, 0, c);
    @(posedge pclk);
    grab <= 1;
    wt(0, 0, c);
    wt(0, 0, c);
    repeat (4) apb(0, OFS_STATUS, 0);
    chk({q[ST_MASTER], q[ST_ARB], irq}, 3'b011);
    grab <= 0;
    apb(1, OFS_STATUS, 32'h1F);
  endtask
  // another master calls our own address 0x54; the monitor flags it
  task t_mon;
    logic [8:0] b;
    b = 9'h0A9;
    grab <= 1;
    for (int i = 0; i < 9; i++) begin
      repeat (4) @(posedge pclk);
      gscl <= 1;
      repeat (2) @(posedge pclk);
      grab <= !b[8 - i];
      repeat (2) @(posedge pclk);
      gscl <= 0;
    end
    repeat (4) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk(q[ST_ADDR], 1);
    rd(OFS_RX_DATA, 32'h54);
  endtask
  task t_sleep;
    light <= 1;
    apb(1, OFS_MASK, 32'h1F);
    apb(1, OFS_COMMAND, 1);
    @(posedge pclk);
    chk(sda_oe, 0);
    light <= 0;
    rd(OFS_MASK, 32'h1F);
    deep <= 1;
    @(posedge pclk);
    deep <= 0;
    rd(OFS_MASK, 0);
    rd(OFS_OWN_ADDR, 0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_start();
    t_send();
    t_mon();
    t_sleep();
    end_sim();
  end
endmodule
